// [tfpa_pkg.sv]
/*
  Package for the timer flag, capture/compare and pulse accumulator block.
  It holds the register byte addresses, field positions, reset values,
  timing constants and the bus request carrier.
  The surroundings are assumed to use byte-wide register access at these
  addresses.
*/
package tfpa_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] ADDR_DIR_SELECT = 6'h00;
  localparam logic [5:0] ADDR_COUNT_HI = 6'h04;
  localparam logic [5:0] ADDR_COUNT_LO = 6'h05;
  localparam logic [5:0] ADDR_SYS_CONTROL = 6'h06;
  localparam logic [5:0] ADDR_PRESCALE = 6'h0D;
  localparam logic [5:0] ADDR_CHAN_FLAGS = 6'h0E;
  localparam logic [5:0] ADDR_OVF_FLAGS = 6'h0F;
  localparam logic [5:0] ADDR_CHAN_BASE = 6'h18;
  localparam logic [5:0] ADDR_ACC_CONTROL = 6'h20;
  localparam logic [5:0] ADDR_ACC_FLAGS = 6'h21;
  localparam logic [5:0] ADDR_ACC_COUNT_HI = 6'h22;
  localparam logic [5:0] ADDR_ACC_COUNT_LO = 6'h23;

  localparam int NUM_CHAN = 4;
  localparam int CHAN_FLAG_LSB = 4;
  localparam int BIT_TIMER_ENABLE = 7;
  localparam int BIT_FAST_CLEAR = 4;
  localparam int BIT_COUNTER_OVF = 7;
  localparam int BIT_ACC_ENABLE = 6;
  localparam int BIT_ACC_MODE = 5;
  localparam int BIT_ACC_EDGE = 4;
  localparam int BIT_CLK_SEL_HI = 3;
  localparam int BIT_CLK_SEL_LO = 2;
  localparam int BIT_ACC_OVF_IE = 1;
  localparam int BIT_ACC_IN_IE = 0;
  localparam int BIT_ACC_OVF_FLAG = 1;
  localparam int BIT_ACC_IN_FLAG = 0;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  localparam logic [1:0] CLK_PRESCALER = 2'h0;
  localparam logic [1:0] CLK_ACC = 2'h1;
  localparam logic [1:0] CLK_ACC_DIV256 = 2'h2;
  localparam logic [1:0] CLK_ACC_DIV65536 = 2'h3;

  localparam int PRESCALE_W = 7;
  localparam logic [5:0] DIV64_ONES = 6'h3F;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tfpa_bus_s;

endpackage : tfpa_pkg

// [tfpa_prescaler.sv]
/*
  Timer prescaler: a free counter that yields the selected prescaler tick
  and the divide-by-64 tick, both as one-cycle enables.
  It assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module tfpa_prescaler (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [2:0] select,
  output logic tick,
  output logic div64_tick
);

  logic [tfpa_pkg::PRESCALE_W-1:0] count_reg;
  logic [tfpa_pkg::PRESCALE_W-1:0] count_next;
  logic [tfpa_pkg::PRESCALE_W-1:0] mask;
  logic [7:0] mask_wide;

  // The count is held at zero while stopped, so both ticks vanish.
  assign count_next = enable ? count_reg + 7'h01 : 7'h00;
  assign mask_wide = (8'h01 << select) - 8'h01;
  assign mask = mask_wide[tfpa_pkg::PRESCALE_W-1:0];
  assign tick = enable & (&(count_reg | ~mask));
  assign div64_tick = enable & (count_reg[5:0] == tfpa_pkg::DIV64_ONES);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : tfpa_prescaler

// [tfpa_pin_sync.sv]
/*
  Two-stage synchroniser for the channel 7 pin with level and edge outputs.
  It assumes the pin may change at any time relative to the clock.
*/
`timescale 1ns/10ps
module tfpa_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // A pin already high at reset release shows one rising edge.
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule : tfpa_pin_sync

// [tfpa_top.sv]
/*
  Timer flags, four capture/compare channels, main counter clock choice and
  the 16-bit pulse accumulator, reached over a plain byte register port.
  It assumes capture edges arrive as one-cycle pulses from edge detectors
  outside, and that the channel 7 pin is asynchronous.
*/
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module tfpa_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tfpa_pkg::tfpa_bus_s bus,
  output logic [7:0] rd_data,
  input wire logic [3:0] capture_edge,
  input wire logic channel7_pin,
  output logic [3:0] compare_match,
  output logic [3:0] channel_flags,
  output logic counter_overflow_flag,
  output logic accumulator_overflow_irq,
  output logic accumulator_input_irq,
  output logic [15:0] timer_count
);

  logic [3:0] dir_reg;
  logic timer_enable_reg;
  logic fast_clear_reg;
  logic [2:0] prescale_reg;
  logic [3:0] chan_flag_reg;
  logic [3:0] chan_flag_next;
  logic ovf_flag_reg;
  logic ovf_flag_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] chan_value_reg [tfpa_pkg::NUM_CHAN];
  logic [6:0] acc_ctrl_reg;
  logic acc_ovf_reg;
  logic acc_ovf_next;
  logic acc_in_reg;
  logic acc_in_next;
  logic [15:0] acc_count_reg;
  logic [15:0] acc_count_next;
  logic [7:0] wbuf_reg;
  logic [7:0] rbuf_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_mux;
  logic [3:0] match_reg;
  logic [3:0] match_now;
  logic [3:0] chan_event;
  logic [3:0] chan_fast_clr;
  logic acc_ovf_irq_reg;
  logic acc_in_irq_reg;

  // Address decode.
  wire access = bus.wr | bus.rd;
  wire hit_dir = bus.addr == tfpa_pkg::ADDR_DIR_SELECT;
  wire hit_cnt_hi = bus.addr == tfpa_pkg::ADDR_COUNT_HI;
  wire hit_cnt_lo = bus.addr == tfpa_pkg::ADDR_COUNT_LO;
  wire hit_sys = bus.addr == tfpa_pkg::ADDR_SYS_CONTROL;
  wire hit_pre = bus.addr == tfpa_pkg::ADDR_PRESCALE;
  wire hit_cflg = bus.addr == tfpa_pkg::ADDR_CHAN_FLAGS;
  wire hit_oflg = bus.addr == tfpa_pkg::ADDR_OVF_FLAGS;
  wire hit_actl = bus.addr == tfpa_pkg::ADDR_ACC_CONTROL;
  wire hit_aflg = bus.addr == tfpa_pkg::ADDR_ACC_FLAGS;
  wire hit_acc_hi = bus.addr == tfpa_pkg::ADDR_ACC_COUNT_HI;
  wire hit_acc_lo = bus.addr == tfpa_pkg::ADDR_ACC_COUNT_LO;
  wire hit_chan = bus.addr[5:3] == tfpa_pkg::ADDR_CHAN_BASE[5:3];
  wire [1:0] chan_idx = bus.addr[2:1];
  wire chan_lo = bus.addr[0];
  wire hit_cnt = hit_cnt_hi | hit_cnt_lo;
  wire hit_acc = hit_acc_hi | hit_acc_lo;
  wire hit_word_hi = hit_cnt_hi | hit_acc_hi | (hit_chan & ~chan_lo);
  wire hit_word_lo = hit_cnt_lo | hit_acc_lo | (hit_chan & chan_lo);

  // Accumulator control fields.
  wire acc_enable = acc_ctrl_reg[tfpa_pkg::BIT_ACC_ENABLE];
  wire acc_mode = acc_ctrl_reg[tfpa_pkg::BIT_ACC_MODE];
  wire acc_edge = acc_ctrl_reg[tfpa_pkg::BIT_ACC_EDGE];
  wire [1:0] clk_sel =
    acc_ctrl_reg[tfpa_pkg::BIT_CLK_SEL_HI:tfpa_pkg::BIT_CLK_SEL_LO];

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic presc_tick;
  logic div64_tick;

  tfpa_pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin(channel7_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  tfpa_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(timer_enable_reg),
    .select(prescale_reg),
    .tick(presc_tick),
    .div64_tick(div64_tick)
  );

  // The same edge counts in event mode and ends the gate in gated mode.
  wire pin_edge = acc_edge ? pin_rise : pin_fall;
  wire gate_open = acc_edge ? ~pin_level : pin_level;
  wire gated_tick = gate_open & div64_tick;
  // Event mode is gated by the accumulator enable alone; gated mode also needs the timer enable, which runs the divide-by-64 tick.
  wire acc_inc = acc_enable & (acc_mode ? gated_tick : pin_edge);
  wire acc_wrap = acc_inc & (acc_count_reg == tfpa_pkg::WORD_MAX);
  wire acc_carry = acc_inc &
    (acc_count_reg[7:0] == tfpa_pkg::BYTE_MAX);
  wire acc_in_set = acc_enable & pin_edge;

  // Clock choice is purely combinational, so a new select acts at once.
  wire use_presc = ~acc_enable | (clk_sel == tfpa_pkg::CLK_PRESCALER);
  wire sel_tick =
    use_presc ? presc_tick :
    (clk_sel == tfpa_pkg::CLK_ACC) ? acc_inc :
    (clk_sel == tfpa_pkg::CLK_ACC_DIV256) ? acc_carry :
    acc_wrap;
  wire count_adv = timer_enable_reg & sel_tick;
  wire count_wrap = count_adv & (count_reg == tfpa_pkg::WORD_MAX);
  assign count_next = count_adv ? count_reg + 16'h0001 : count_reg;

  // Word assembled from the buffered high byte and the low byte now.
  wire [15:0] wr_word = {wbuf_reg, bus.wdata};
  wire [15:0] chan_sel_value = chan_value_reg[chan_idx];
  wire [15:0] word_sel =
    hit_cnt ? count_reg :
    hit_acc ? acc_count_reg :
    chan_sel_value;

  // Main counter overflow flag.
  wire ovf_clr_wr = bus.wr & hit_oflg &
    bus.wdata[tfpa_pkg::BIT_COUNTER_OVF];
  wire ovf_clr_fast = fast_clear_reg & hit_cnt & access;
  assign ovf_flag_next = count_wrap ? 1'b1 :
    (ovf_clr_wr | ovf_clr_fast) ? 1'b0 : ovf_flag_reg;

  // Accumulator flags.
  wire acc_clr_fast = fast_clear_reg & hit_acc & access;
  wire acc_ovf_clr = (bus.wr & hit_aflg &
    bus.wdata[tfpa_pkg::BIT_ACC_OVF_FLAG]) | acc_clr_fast;
  wire acc_in_clr = (bus.wr & hit_aflg &
    bus.wdata[tfpa_pkg::BIT_ACC_IN_FLAG]) | acc_clr_fast;
  assign acc_ovf_next = acc_wrap ? 1'b1 :
    acc_ovf_clr ? 1'b0 : acc_ovf_reg;
  assign acc_in_next = acc_in_set ? 1'b1 :
    acc_in_clr ? 1'b0 : acc_in_reg;

  // A software write to the count wins over a coincident increment.
  wire acc_write = bus.wr & hit_acc_lo;
  assign acc_count_next = acc_write ? wr_word :
    acc_inc ? acc_count_reg + 16'h0001 : acc_count_reg;

  // Per-channel capture, compare, flags and write gating.
  genvar gi;
  generate
    for (gi = 0; gi < tfpa_pkg::NUM_CHAN; gi++) begin : g_chan
      wire is_oc = dir_reg[gi];
      wire sel_me = hit_chan & (chan_idx == 2'(gi));
      wire cap_now = ~is_oc & capture_edge[gi];
      wire oc_write = bus.wr & sel_me & chan_lo & is_oc;
      assign match_now[gi] = is_oc & count_adv &
        (count_next == chan_value_reg[gi]);
      assign chan_event[gi] = cap_now | match_now[gi];
      assign chan_fast_clr[gi] = fast_clear_reg & sel_me &
        ((bus.rd & ~is_oc) | (bus.wr & is_oc));
      wire flag_clr = (bus.wr & hit_cflg &
        bus.wdata[tfpa_pkg::CHAN_FLAG_LSB + gi]) | chan_fast_clr[gi];
      assign chan_flag_next[gi] = chan_event[gi] ? 1'b1 :
        flag_clr ? 1'b0 : chan_flag_reg[gi];

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          chan_value_reg[gi] <= tfpa_pkg::RESET_WORD;
        end else if (cap_now) begin
          chan_value_reg[gi] <= count_reg;
        end else if (oc_write) begin
          chan_value_reg[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // Read selection; the low byte of a word comes from the snapshot buffer.
  wire [7:0] sys_rd = {timer_enable_reg, 2'h0, fast_clear_reg, 4'h0};
  wire [7:0] cflg_rd = {chan_flag_reg, 4'h0};
  wire [7:0] oflg_rd = {ovf_flag_reg, 7'h00};
  wire [7:0] aflg_rd = {6'h00, acc_ovf_reg, acc_in_reg};
  assign rd_mux =
    hit_word_hi ? word_sel[15:8] :
    hit_word_lo ? rbuf_reg :
    hit_dir ? {dir_reg, 4'h0} :
    hit_sys ? sys_rd :
    hit_pre ? {5'h00, prescale_reg} :
    hit_cflg ? cflg_rd :
    hit_oflg ? oflg_rd :
    hit_actl ? {1'b0, acc_ctrl_reg} :
    hit_aflg ? aflg_rd :
    tfpa_pkg::RESET_BYTE;

  // Control registers written by software.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dir_reg <= 4'h0;
      timer_enable_reg <= 1'b0;
      fast_clear_reg <= 1'b0;
      prescale_reg <= 3'h0;
      acc_ctrl_reg <= 7'h00;
    end else if (bus.wr) begin
      if (hit_dir) begin
        dir_reg <= bus.wdata[7:4];
      end
      if (hit_sys) begin
        timer_enable_reg <= bus.wdata[tfpa_pkg::BIT_TIMER_ENABLE];
        fast_clear_reg <= bus.wdata[tfpa_pkg::BIT_FAST_CLEAR];
      end
      if (hit_pre) begin
        prescale_reg <= bus.wdata[2:0];
      end
      if (hit_actl) begin
        acc_ctrl_reg <= bus.wdata[6:0];
      end
    end
  end

  // Counters and flags.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= tfpa_pkg::RESET_WORD;
      acc_count_reg <= tfpa_pkg::RESET_WORD;
      chan_flag_reg <= 4'h0;
      ovf_flag_reg <= 1'b0;
      acc_ovf_reg <= 1'b0;
      acc_in_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      acc_count_reg <= acc_count_next;
      chan_flag_reg <= chan_flag_next;
      ovf_flag_reg <= ovf_flag_next;
      acc_ovf_reg <= acc_ovf_next;
      acc_in_reg <= acc_in_next;
    end
  end

  // Byte pairing buffers: a high-byte write fills wbuf_reg and a high-byte read fills rbuf_reg for the low byte.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wbuf_reg <= tfpa_pkg::RESET_BYTE;
      rbuf_reg <= tfpa_pkg::RESET_BYTE;
    end else begin
      if (bus.wr & hit_word_hi) begin
        wbuf_reg <= bus.wdata;
      end
      if (bus.rd & hit_word_hi) begin
        rbuf_reg <= word_sel[7:0];
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data_reg <= tfpa_pkg::RESET_BYTE;
      match_reg <= 4'h0;
      acc_ovf_irq_reg <= 1'b0;
      acc_in_irq_reg <= 1'b0;
    end else begin
      rd_data_reg <= bus.rd ? rd_mux : tfpa_pkg::RESET_BYTE;
      match_reg <= match_now;
      acc_ovf_irq_reg <= acc_ovf_next &
        acc_ctrl_reg[tfpa_pkg::BIT_ACC_OVF_IE];
      acc_in_irq_reg <= acc_in_next &
        acc_ctrl_reg[tfpa_pkg::BIT_ACC_IN_IE];
    end
  end

  assign rd_data = rd_data_reg;
  assign compare_match = match_reg;
  assign channel_flags = chan_flag_reg;
  assign counter_overflow_flag = ovf_flag_reg;
  assign accumulator_overflow_irq = acc_ovf_irq_reg;
  assign accumulator_input_irq = acc_in_irq_reg;
  assign timer_count = count_reg;

endmodule : tfpa_top

// [tfpa_props.sv]
/*
  Checker for the timer flag and pulse accumulator block, bound to its top.
  It assumes it sees only the top ports and shadows the control registers
  from the byte bus writes.
*/
`timescale 1ns/10ps
module tfpa_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tfpa_pkg::tfpa_bus_s bus,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] capture_edge,
  input wire logic channel7_pin,
  input wire logic [3:0] compare_match,
  input wire logic [3:0] channel_flags,
  input wire logic counter_overflow_flag,
  input wire logic accumulator_overflow_irq,
  input wire logic accumulator_input_irq,
  input wire logic [15:0] timer_count
);
  logic [7:0] sys_reg;
  logic [7:0] acc_reg;
  logic [2:0] psel_reg;
  wire wr_sys = bus.wr && bus.addr == tfpa_pkg::ADDR_SYS_CONTROL;
  wire wr_acc = bus.wr && bus.addr == tfpa_pkg::ADDR_ACC_CONTROL;
  wire wr_psel = bus.wr && bus.addr == tfpa_pkg::ADDR_PRESCALE;
  wire wr_chf = bus.wr && bus.addr == tfpa_pkg::ADDR_CHAN_FLAGS;
  wire wr_ovf = bus.wr && bus.addr == tfpa_pkg::ADDR_OVF_FLAGS;
  wire cnt_acc = (bus.wr || bus.rd) && (bus.addr == tfpa_pkg::ADDR_COUNT_HI
    || bus.addr == tfpa_pkg::ADDR_COUNT_LO);
  wire timer_enable = sys_reg[7];
  wire ffc = sys_reg[4];
  wire acc_en = acc_reg[6];
  wire not_top = timer_count != 16'hFFFF;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sys_reg <= 8'h00;
      acc_reg <= 8'h00;
      psel_reg <= 3'h0;
    end else begin
      if (wr_sys) sys_reg <= bus.wdata;
      if (wr_acc) acc_reg <= bus.wdata;
      if (wr_psel) psel_reg <= bus.wdata[2:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ovf_set_a: assert property (($past(timer_count) == 16'hFFFF &&
    timer_count == 16'h0000) |-> counter_overflow_flag)
    else $error("overflow flag missing after wrap");
  ovf_clear_a: assert property (wr_ovf && bus.wdata[7] && not_top
    |=> !counter_overflow_flag) else $error("overflow flag not cleared");
  ovf_fast_a: assert property (ffc && cnt_acc && not_top
    |=> !counter_overflow_flag) else $error("fast clear of overflow failed");
  cnt_step_a: assert property (timer_count != $past(timer_count)
    |-> timer_count == 16'($past(timer_count) + 16'h0001))
    else $error("main counter jumped");
  cnt_hold_a: assert property (!$past(timer_enable) |-> $stable(timer_count))
    else $error("main counter ran while timer off");
  cnt_div1_a: assert property ($past(timer_enable) && !$past(acc_en) &&
    $past(psel_reg) == 3'h0
    |-> timer_count == 16'($past(timer_count) + 16'h0001))
    else $error("divide by one rate wrong");
  chan_set_a: assert property (capture_edge != 4'h0 |=>
    (channel_flags & $past(capture_edge)) == $past(capture_edge))
    else $error("channel flag not set by event");
  chan_clear_a: assert property (wr_chf && capture_edge == 4'h0 |=>
    (channel_flags & $past(bus.wdata[7:4])) == 4'h0)
    else $error("channel flag not cleared");
  ovf_irq_a: assert property (accumulator_overflow_irq
    |-> acc_reg[1] || $past(acc_reg[1])) else $error("overflow irq unmasked");
  in_irq_a: assert property (accumulator_input_irq
    |-> acc_reg[0] || $past(acc_reg[0])) else $error("input irq unmasked");

  cover property (compare_match[0]);
  cover property (accumulator_overflow_irq);
  cover property ($rose(counter_overflow_flag));
endmodule : tfpa_props

bind tfpa_top tfpa_props i_props (.sys_clk, .rst_n, .bus, .rd_data,
  .capture_edge, .channel7_pin, .compare_match, .channel_flags,
  .counter_overflow_flag, .accumulator_overflow_irq, .accumulator_input_irq,
  .timer_count);

// [tfpa_pin_model.sv]
/*
  Source of the channel 7 pin: edge pulses and gate levels.
  It assumes the bench calls its tasks; the pin idles low.
*/
`timescale 1ns/10ps
module tfpa_pin_model (
  input wire logic sys_clk,
  output logic pin
);
  initial pin = 1'b0;

  // Widths stay above two bus clocks, else the synchroniser may miss one.
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(negedge sys_clk) pin = 1'b1;
      repeat (w) @(negedge sys_clk);
      pin = 1'b0;
      repeat (w) @(negedge sys_clk);
    end
    repeat (4) @(negedge sys_clk);
  endtask : pulse

  task automatic gate(input logic lvl, input int cyc);
    @(negedge sys_clk) pin = lvl;
    repeat (cyc) @(negedge sys_clk);
    pin = ~lvl;
    repeat (8) @(negedge sys_clk);
  endtask : gate
endmodule : tfpa_pin_model

// [tb_timer_flags_pulse_accumulator.sv]
/*
  Self-checking bench for the timer flag and pulse accumulator block.
  It assumes the byte register port and the pin model beside it.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb_timer_flags_pulse_accumulator;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  tfpa_pkg::tfpa_bus_s bus_r = '0;
  logic [3:0] cap_r = 4'h0;
  logic [7:0] rd_data;
  logic [3:0] compare_match;
  logic [3:0] channel_flags;
  logic counter_overflow_flag;
  logic accumulator_overflow_irq;
  logic accumulator_input_irq;
  logic [15:0] timer_count;
  logic pin;
  logic [15:0] t0;
  int n_errors = 0;
  int n_compared = 0;

  initial forever #50 sys_clk = ~sys_clk;

  tfpa_pin_model i_pin (.sys_clk(sys_clk), .pin(pin));
  tfpa_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_r),
    .rd_data(rd_data), .capture_edge(cap_r), .channel7_pin(pin),
    .compare_match(compare_match), .channel_flags(channel_flags),
    .counter_overflow_flag(counter_overflow_flag),
    .accumulator_overflow_irq(accumulator_overflow_irq),
    .accumulator_input_irq(accumulator_input_irq), .timer_count(timer_count));

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_r <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_r <= '0;
    // Let the write edge settle before any caller looks at the outputs.
    #1;
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_r <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_r <= '0;
    #1 `CHK(rd_data, e)
  endtask : rdc

  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(6'(a + 6'h01), v[7:0]);
  endtask : wr16

  task automatic rd16c(input logic [5:0] a, input logic [15:0] e);
    rdc(a, e[15:8]);
    rdc(6'(a + 6'h01), e[7:0]);
  endtask : rd16c

  task automatic done(input string s);
    $display("test %s done, mismatches so far %0d", s, n_errors);
  endtask : done

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdc(6'(tfpa_pkg::ADDR_CHAN_BASE + a), 8'h00);
    end
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h00);
    wr16(tfpa_pkg::ADDR_CHAN_BASE, 16'h1234);
    rd16c(tfpa_pkg::ADDR_CHAN_BASE, 16'h0000);
    wr(tfpa_pkg::ADDR_DIR_SELECT, 8'hF0);
    for (int c = 0; c < 4; c++) begin
      wr16(6'(tfpa_pkg::ADDR_CHAN_BASE + 2 * c), 16'(16'hA5C0 + c));
      rd16c(6'(tfpa_pkg::ADDR_CHAN_BASE + 2 * c), 16'(16'hA5C0 + c));
    end
    wr(tfpa_pkg::ADDR_DIR_SELECT, 8'h00);
    done("registers");
    // Counter clocked by the accumulator, so every count is exact.
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h57);
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h80);
    i_pin.pulse(5, 3);
    `CHK(timer_count, 16'h0005)
    rd16c(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0005);
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h01);
    `CHK(accumulator_input_irq, 1'b1)
    @(posedge sys_clk) cap_r <= 4'h2;
    @(posedge sys_clk) cap_r <= 4'h0;
    rd16c(6'h1A, 16'h0005);
    `CHK(channel_flags, 4'h2)
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h45);
    i_pin.pulse(3, 6);
    `CHK(timer_count, 16'h0008)
    wr16(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h00FE);
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h49);
    i_pin.pulse(2, 3);
    `CHK(timer_count, 16'h0009)
    wr16(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'hFFFF);
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h4E);
    i_pin.pulse(1, 3);
    `CHK(timer_count, 16'h000A)
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h03);
    `CHK(accumulator_overflow_irq, 1'b1)
    `CHK(accumulator_input_irq, 1'b0)
    wr(tfpa_pkg::ADDR_ACC_FLAGS, 8'h02);
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h01);
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h90);
    rd16c(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0000);
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h00);
    rd16c(6'h1A, 16'h0005);
    `CHK(channel_flags[1], 1'b0)
    @(posedge sys_clk);
    bus_r <= '{tfpa_pkg::ADDR_CHAN_FLAGS, 8'h40, 1'b1, 1'b0};
    cap_r <= 4'h4;
    @(posedge sys_clk);
    bus_r <= '0;
    cap_r <= 4'h0;
    #1 `CHK(channel_flags[2], 1'b1)
    wr(tfpa_pkg::ADDR_CHAN_FLAGS, 8'hF0);
    `CHK(channel_flags, 4'h0)
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h80);
    done("event counting");
    wr(tfpa_pkg::ADDR_ACC_FLAGS, 8'h03);
    wr16(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0000);
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h60);
    i_pin.gate(1'b1, 640);
    rd16c(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h000A);
    rdc(tfpa_pkg::ADDR_ACC_FLAGS, 8'h01);
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h00);
    wr16(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0000);
    i_pin.gate(1'b1, 640);
    rd16c(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0000);
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h50);
    i_pin.pulse(2, 6);
    rd16c(tfpa_pkg::ADDR_ACC_COUNT_HI, 16'h0002);
    done("gated");
    // Clock select 11 must be ignored while the accumulator is off.
    wr(tfpa_pkg::ADDR_ACC_CONTROL, 8'h0C);
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h80);
    for (int p = 0; p < 8; p++) begin
      wr(tfpa_pkg::ADDR_PRESCALE, 8'(p));
      @(posedge sys_clk);
      #1 t0 = timer_count;
      repeat (128) @(posedge sys_clk);
      #1 `CHK(16'(timer_count - t0), 16'(16'h0080 >> p))
    end
    done("prescaler");
    wr(tfpa_pkg::ADDR_PRESCALE, 8'h00);
    wr(tfpa_pkg::ADDR_DIR_SELECT, 8'h10);
    wr16(tfpa_pkg::ADDR_CHAN_BASE, 16'h8000);
    for (int i = 0; i < 70000 && counter_overflow_flag !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
      if (compare_match[0] === 1'b1) `CHK(timer_count, 16'h8000)
    end
    if (counter_overflow_flag !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    `CHK(channel_flags[0], 1'b1)
    wr(tfpa_pkg::ADDR_OVF_FLAGS, 8'h7F);
    `CHK(counter_overflow_flag, 1'b1)
    wr(tfpa_pkg::ADDR_SYS_CONTROL, 8'h90);
    rdc(tfpa_pkg::ADDR_PRESCALE, 8'h00);
    wr(tfpa_pkg::ADDR_COUNT_HI, 8'h00);
    `CHK(counter_overflow_flag, 1'b0)
    wr(tfpa_pkg::ADDR_CHAN_BASE, 8'h80);
    `CHK(channel_flags[0], 1'b0)
    wr(tfpa_pkg::ADDR_OVF_FLAGS, 8'h80);
    done("overflow");
    end_sim();
  end
endmodule : tb_timer_flags_pulse_accumulator
